// ===== src/sshift_pkg.sv
// constants, register map and carrier types of the serial shift block
// assumes an apb slave with 32-bit data, one register per aligned word
//
// What this block does
// - 8-bit shift register and 4-bit counter; msb first out, serial input captured.
// - a falling edge of the shift clock advances register and counter while the count is below eight and no data write coincides.
// - after eight pulses terminal output falls and blocks further clocking.
// - interrupt on eighth falling edge unless a data write reset the counter.
// - processor reset leaves the serial interrupt disabled.
// - data write enables interrupt; any write to disable register disables it.
// - interrupt request is a high-to-low transition.
// - reset or data write clears counter and enables the shift clock.
// - interrupt means byte received or sent; software acknowledges on ninth pulse.
// - in master use software drives the shift clock pin level.
// - serial input is input; open-drain mode puts register msb on output pin.
// - without open-drain mode the register never reaches the output pin.
// - software may hold serial input low, and hold the clock low only with scl_master set.
// - shift register sits at index DDh; its write arms the interrupt.
// - disable register sits at index C2h; any write disables the interrupt.
// - leaving the data register unwritten keeps the interrupt off.
// - clock may come from software or an external source.
package sshift_pkg;

    // ***********************************
    // register map
    // ***********************************
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_SHIFT = 10'h0DD;
    localparam logic [9:0] IDX_IRQ_DIS = 10'h0C2;
    localparam logic [9:0] IDX_PIN_CTRL = 10'h0C0;
    localparam logic [9:0] IDX_STATUS = 10'h0C1;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] COUNT_FULL = 4'h8;

    // ***********************************
    // pin control fields
    // ***********************************
    typedef struct packed {
        logic sin_hold_low;
        logic sout_open_drain;
        logic scl_level;
        logic scl_master;
    } pin_ctrl_t;

    localparam pin_ctrl_t PIN_CTRL_RESET = '{sin_hold_low: 1'b0, sout_open_drain: 1'b0,
                                             scl_level: 1'b1, scl_master: 1'b0};

    // status word: {irq_n, irq_enable, terminal, count}
    typedef struct packed {
        logic irq_n;
        logic irq_enable;
        logic counter_terminal_output;
        logic [3:0] count;
    } status_t;

endpackage

// ===== src/serial_shift_interface.sv
// serial shift peripheral with apb register access
// assumes pins arrive asynchronously and are resolved open-drain outside
`timescale 1ns/100ps
module serial_shift_interface
    import sshift_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SIN_I,
    output logic SIN_O,
    output logic SIN_OE,
    output logic SOUT_O,
    output logic SOUT_OE,
    output logic SERIAL_IRQ_N
);

    // ***********************************
    // declarations
    // ***********************************
    logic [7:0] shift_data;
    logic [3:0] count;
    logic irq_enable;
    logic irq_n;
    pin_ctrl_t pin_ctrl;
    logic scl_meta, scl_sync, scl_prev;
    logic sin_meta, sin_sync;
    logic scl_fall;
    logic counter_terminal_output;
    logic setup;
    logic access_wr;
    logic [9:0] idx;
    logic mapped;
    logic wr_shift, wr_dis, wr_ctrl;
    logic advance;
    status_t status;

    // ***********************************
    // pin synchronisers
    // ***********************************
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            scl_meta <= SCL_I;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sin_meta <= 1'b1;
            sin_sync <= 1'b1;
        end else begin
            sin_meta <= SIN_I;
            sin_sync <= sin_meta;
        end
    end

    // falling edge of the shift clock, whatever drives it
    assign scl_fall = scl_prev & ~scl_sync;

    // ***********************************
    // apb decode
    // ***********************************
    assign setup = PSEL & ~PENABLE;
    assign access_wr = PSEL & PENABLE & PWRITE;
    assign idx = PADDR[11:2];
    assign mapped = (idx == IDX_SHIFT) || (idx == IDX_IRQ_DIS) || (idx == IDX_PIN_CTRL)
                    || (idx == IDX_STATUS);
    assign wr_shift = access_wr & (idx == IDX_SHIFT);
    assign wr_dis = access_wr & (idx == IDX_IRQ_DIS);
    assign wr_ctrl = access_wr & (idx == IDX_PIN_CTRL);
    assign PREADY = 1'b1;

    assign status = '{irq_n: irq_n, irq_enable: irq_enable,
                      counter_terminal_output: counter_terminal_output, count: count};

    // read data captured in the setup cycle, valid in the access cycle
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PSLVERR <= ~mapped;
            unique case (idx)
                IDX_SHIFT: PRDATA <= {24'h00_0000, shift_data};
                IDX_PIN_CTRL: PRDATA <= {28'h000_0000, pin_ctrl};
                IDX_STATUS: PRDATA <= {25'h000_0000, status};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ***********************************
    // pin control register
    // ***********************************
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pin_ctrl <= PIN_CTRL_RESET;
        end else if (wr_ctrl) begin
            pin_ctrl <= pin_ctrl_t'(PWDATA[3:0]);
        end
    end

    // master drives the clock low itself; slave leaves the pin to the partner
    assign SCL_O = 1'b0;
    assign SCL_OE = pin_ctrl.scl_master & ~pin_ctrl.scl_level;
    // acknowledge: software pulls the serial input low
    assign SIN_O = 1'b0;
    assign SIN_OE = pin_ctrl.sin_hold_low;
    // open-drain output shows register msb only in open-drain mode
    assign SOUT_O = 1'b0;
    assign SOUT_OE = pin_ctrl.sout_open_drain & ~shift_data[7];

    // ***********************************
    // shift register and counter
    // ***********************************
    assign counter_terminal_output = ~count[3];
    assign advance = scl_fall & counter_terminal_output & ~wr_shift;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            shift_data <= SHIFT_RESET;
        end else if (wr_shift) begin
            shift_data <= PWDATA[7:0];
        end else if (advance) begin
            shift_data <= {shift_data[6:0], sin_sync};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            count <= COUNT_RESET;
        end else if (wr_shift) begin
            count <= COUNT_RESET;
        end else if (advance) begin
            count <= count + 4'h1;
        end
    end

    // ***********************************
    // interrupt
    // ***********************************
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            irq_enable <= 1'b0;
        end else if (wr_shift) begin
            irq_enable <= 1'b1;
        end else if (wr_dis) begin
            irq_enable <= 1'b0;
        end
    end

    // request falls on the eighth edge and rises on the next data or disable register write
    // an eighth edge wins over a disable write in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            irq_n <= 1'b1;
        end else if (wr_shift) begin
            irq_n <= 1'b1;
        end else if (advance && count == 4'h7 && irq_enable) begin
            irq_n <= 1'b0;
        end else if (wr_dis) begin
            irq_n <= 1'b1;
        end
    end

    assign SERIAL_IRQ_N = irq_n;

    // ***********************************
    // reference model for the assertions
    // ***********************************
    logic [4:0] fall_tally;
    logic [7:0] ref_data;
    logic ref_armed;
    logic ref_req_n;

    // falls seen since the last data write, saturating
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            fall_tally <= 5'h00;
        end else if (wr_shift) begin
            fall_tally <= 5'h00;
        end else if (scl_fall && fall_tally != 5'h1F) begin
            fall_tally <= fall_tally + 5'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ref_data <= SHIFT_RESET;
        end else if (wr_shift) begin
            ref_data <= PWDATA[7:0];
        end else if (scl_fall && fall_tally < {1'b0, COUNT_FULL}) begin
            ref_data <= {ref_data[6:0], sin_sync};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ref_armed <= 1'b0;
        end else if (wr_shift) begin
            ref_armed <= 1'b1;
        end else if (wr_dis) begin
            ref_armed <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ref_req_n <= 1'b1;
        end else if (wr_shift) begin
            ref_req_n <= 1'b1;
        end else if (scl_fall && fall_tally == 5'h07 && ref_armed) begin
            ref_req_n <= 1'b0;
        end else if (wr_dis) begin
            ref_req_n <= 1'b1;
        end
    end

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);

    a_count_clear_write: assert property (wr_shift |=> count == COUNT_RESET)
        else $error("counter not cleared by data write");

    a_irq_arm_write: assert property (wr_shift |=> irq_enable && irq_n)
        else $error("data write did not arm interrupt");

    a_irq_disable_write: assert property (wr_dis && !wr_shift |=> !irq_enable)
        else $error("disable write did not disable interrupt");

    a_terminal_blocks_clock: assert property (
        count == COUNT_FULL && !wr_shift |=> count == COUNT_FULL && $stable(shift_data))
        else $error("clocking continued after eight pulses");

    a_irq_fall_cause: assert property (
        $fell(irq_n) |-> count == COUNT_FULL && $past(irq_enable) && $past(count) == 4'h7)
        else $error("interrupt fell without eighth edge");

    a_eighth_edge_irq: assert property (
        advance && count == 4'h7 && irq_enable |=> !SERIAL_IRQ_N)
        else $error("eighth edge raised no interrupt");

    a_msb_first_shift: assert property (
        advance |=> shift_data == {$past(shift_data[6:0]), $past(sin_sync)})
        else $error("shift direction or input bit wrong");

    a_read_no_effect: assert property (
        PSEL && !PWRITE && idx == IDX_SHIFT && !scl_fall |=> $stable(count)
        && $stable(irq_enable))
        else $error("read changed counter or enable");

    a_quiet_when_disabled: assert property (
        !irq_enable && irq_n |=> SERIAL_IRQ_N)
        else $error("interrupt while disabled");

    a_gpio_sout_free: assert property (!pin_ctrl.sout_open_drain |-> !SOUT_OE)
        else $error("register reached output outside open-drain mode");

    a_reset_leaves_quiet: assert property (
        $fell(SRST) |-> !irq_enable && irq_n && count == COUNT_RESET && shift_data == SHIFT_RESET)
        else $error("reset left block active");

    a_write_loads_data: assert property (
        wr_shift |=> shift_data == $past(PWDATA[7:0]))
        else $error("data write not loaded");

    a_irq_held_low: assert property (
        !irq_n && !wr_shift && !wr_dis |=> !irq_n)
        else $error("request released without a write");

    a_irq_rise_cause: assert property (
        $rose(irq_n) |-> $past(wr_shift) || $past(wr_dis) || $past(SRST))
        else $error("request released without cause");

    a_count_never_over: assert property (
        count <= COUNT_FULL)
        else $error("counter passed eight");

    a_terminal_means_full: assert property (
        !counter_terminal_output |-> count == COUNT_FULL)
        else $error("terminal output low before eight pulses");

    a_fall_advances: assert property (
        $fell(scl_sync) && count != COUNT_FULL && !wr_shift |=> count == $past(count) + 4'h1)
        else $error("falling edge did not advance counter");

    a_count_tracks_edges: assert property (
        fall_tally < {1'b0, COUNT_FULL} |-> count == fall_tally[3:0])
        else $error("counter differs from falls seen");

    a_count_saturates: assert property (
        fall_tally >= {1'b0, COUNT_FULL} |-> count == COUNT_FULL)
        else $error("counter not held at eight");

    a_ack_pull_low: assert property (
        pin_ctrl.sin_hold_low |-> SIN_OE && !SIN_O)
        else $error("acknowledge not pulled low");

    a_master_pulls_clock: assert property (
        pin_ctrl.scl_master && !pin_ctrl.scl_level |-> SCL_OE && !SCL_O)
        else $error("master clock not driven low");

    a_slave_releases_clock: assert property (
        !pin_ctrl.scl_master |-> !SCL_OE)
        else $error("slave drove the clock pin");

    a_sout_shows_msb: assert property (
        pin_ctrl.sout_open_drain |-> SOUT_OE == !shift_data[7] && !SOUT_O)
        else $error("output pin does not show msb");

    a_read_returns_data: assert property (
        setup && idx == IDX_SHIFT |=> PRDATA == {24'h00_0000, $past(shift_data)})
        else $error("read data differs from register");

    a_irq_needs_enable: assert property (
        $fell(SERIAL_IRQ_N) |-> $past(irq_enable))
        else $error("request while interrupt disabled");

    a_write_drops_edge: assert property (
        wr_shift && scl_fall |=> count == COUNT_RESET && shift_data == $past(PWDATA[7:0]))
        else $error("edge beat a data write");

    a_data_matches_model: assert property (
        shift_data == ref_data)
        else $error("shift register differs from model");

    a_irq_matches_model: assert property (
        SERIAL_IRQ_N == ref_req_n)
        else $error("interrupt request differs from model");

    a_enable_matches_model: assert property (
        irq_enable == ref_armed)
        else $error("interrupt enable differs from model");

    a_disable_keeps_data: assert property (
        wr_dis && !scl_fall |=> $stable(shift_data) && $stable(count))
        else $error("disable write changed data or counter");

    a_ctrl_keeps_count: assert property (
        wr_ctrl && !scl_fall |=> $stable(count) && $stable(irq_enable))
        else $error("pin control write changed counter");

    a_clock_two_stages: assert property (
        scl_fall |-> !$past(scl_meta) && $past(scl_meta, 2))
        else $error("clock edge not taken through two stages");

    a_input_two_stages: assert property (
        !$past(SRST) |-> sin_sync == $past(sin_meta))
        else $error("serial input not taken through two stages");

    c_full_byte: cover property (wr_shift ##[1:1000] $fell(SERIAL_IRQ_N));
    c_write_restart: cover property (count == 4'h5 ##1 wr_shift);
    c_disabled_byte: cover property (!irq_enable && count == COUNT_FULL);
    c_master_edge: cover property (pin_ctrl.scl_master && scl_fall);
    c_edge_ignored: cover property (count == COUNT_FULL && scl_fall);

endmodule

// ===== tb/sshift_partner.sv
// serial bus master model: drives shift clock and data line, samples output
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/100ps
module sshift_partner (
    output logic scl,
    output logic sin,
    input wire logic sout
);
    initial begin
        scl = 1'b1;
        sin = 1'b1;
    end
    // ************************
    // one byte, msb first, clock idle high outside frames
    // ************************
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sin <= tx[i];
            #160;
            rx[i] = sout;
            scl <= 1'b0;
            #160;
            scl <= 1'b1;
        end
        #160;
        sin <= 1'b1;
    endtask
endmodule

// ===== tb/serial_shift_interface_tb.sv
// self-checking bench for the serial shift block
// assumes apb access, open-drain pins with pull-ups, partner as bus master
`timescale 1ns/100ps
module serial_shift_interface_tb
    import sshift_pkg::*;
;
    logic SYS_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SERIAL_IRQ_N;
    logic [ADDR_W-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r;
    logic SCL_O, SCL_OE, SIN_O, SIN_OE, SOUT_O, SOUT_OE, p_scl, p_sin, e;
    logic [7:0] rx;
    int miscompares, checked;
    localparam logic [11:0] A_SH = {IDX_SHIFT, 2'b00};
    localparam logic [11:0] A_DI = {IDX_IRQ_DIS, 2'b00};
    localparam logic [11:0] A_CT = {IDX_PIN_CTRL, 2'b00};
    localparam logic [11:0] A_ST = {IDX_STATUS, 2'b00};
    wire logic scl_line = p_scl & (~SCL_OE | SCL_O);
    wire logic sin_line = p_sin & (~SIN_OE | SIN_O);
    wire logic sout_line = ~SOUT_OE | SOUT_O;

    serial_shift_interface dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_I(scl_line),
        .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SIN_I(sin_line), .SIN_O(SIN_O),
        .SIN_OE(SIN_OE), .SOUT_O(SOUT_O), .SOUT_OE(SOUT_OE),
        .SERIAL_IRQ_N(SERIAL_IRQ_N));
    sshift_partner partner (.scl(p_scl), .sin(p_sin), .sout(sout_line));

    // ************************
    // shared tasks
    // ************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************
    // scenarios
    // ************************
    task automatic t_reset;
        apb(1'b0, A_SH, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        chk(r, 32'h50);
        chk(SERIAL_IRQ_N, 1'b1);
        apb(1'b0, 12'hFFC, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, A_SH, 32'h0);
        chk(SOUT_OE, 1'b0);
    endtask
    task automatic t_slave;
        apb(1'b1, A_CT, 32'h4);
        apb(1'b1, A_SH, 32'hA5);
        partner.xfer(8'h3C, rx);
        chk(rx, 8'hA5);
        repeat (4) @(posedge SYS_CLK);
        apb(1'b0, A_SH, 32'h0);
        chk(r, 32'h3C);
        chk(SERIAL_IRQ_N, 1'b0);
        apb(1'b0, A_ST, 32'h0);
        chk(r, 32'h28);
        partner.xfer(8'hFF, rx);
        apb(1'b0, A_SH, 32'h0);
        chk(r, 32'h3C);
        chk(SERIAL_IRQ_N, 1'b0);
    endtask
    task automatic t_disable;
        apb(1'b1, A_DI, 32'h0);
        @(posedge SYS_CLK);
        chk(SERIAL_IRQ_N, 1'b1);
        apb(1'b1, A_SH, 32'h81);
        apb(1'b1, A_DI, 32'h5A);
        partner.xfer(8'h00, rx);
        repeat (4) @(posedge SYS_CLK);
        chk(SERIAL_IRQ_N, 1'b1);
        apb(1'b0, A_ST, 32'h0);
        chk(r, 32'h48);
        apb(1'b0, A_SH, 32'h0);
        chk(r, 32'h0);
    endtask
    task automatic t_master;
        apb(1'b1, A_SH, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_CT, 32'h1);
            repeat (3) @(posedge SYS_CLK);
            chk(scl_line, 1'b0);
            apb(1'b1, A_CT, 32'h3);
            repeat (3) @(posedge SYS_CLK);
        end
        repeat (4) @(posedge SYS_CLK);
        apb(1'b0, A_SH, 32'h0);
        chk(r, 32'hFF);
        chk(SERIAL_IRQ_N, 1'b0);
    endtask
    task automatic t_hold;
        apb(1'b1, A_CT, 32'h8);
        @(posedge SYS_CLK);
        chk(sin_line, 1'b0);
        apb(1'b1, A_CT, 32'h0);
        @(posedge SYS_CLK);
        chk(sin_line, 1'b1);
    endtask

    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #1000000;
        miscompares++;
        give_verdict;
    end
    initial begin
        SRST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = '0;
        PWDATA = '0;
        miscompares = 0;
        checked = 0;
        repeat (4) @(posedge SYS_CLK);
        SRST <= 1'b0;
        t_reset;
        t_slave;
        t_disable;
        t_master;
        t_hold;
        give_verdict;
    end
endmodule
